// File: logic/urcp_defs.vh
// Constants for the UART register command port
`ifndef URCP_DEFS_VH
`define URCP_DEFS_VH

// Reference clock
`define URCP_CLK_HZ 20000000
`define URCP_CLK_MHZ 20

// Command codes
`define URCP_CMD_WRITE 8'hF5
`define URCP_CMD_READ 8'hFD

// Register addresses
`define URCP_ADDR_CTRL0 8'h00
`define URCP_ADDR_CTRL1 8'h01
`define URCP_ADDR_FREQ_MAIN 8'h02
`define URCP_ADDR_FREQ_ALT1 8'h03
`define URCP_ADDR_FREQ_ALT2 8'h04
`define URCP_ADDR_FREQ_ACTIVE 8'h05
`define URCP_ADDR_SLEEP 8'h06
`define URCP_ADDR_UID_4740 8'h96
`define URCP_ADDR_UID_3932 8'h97
`define URCP_ADDR_UID_3124 8'h98
`define URCP_ADDR_UID_2316 8'h99
`define URCP_ADDR_UID_1508 8'h9A
`define URCP_ADDR_UID_0700 8'h9B

// Reset values
`define URCP_RST_CTRL0 8'h2A
`define URCP_RST_CTRL1 8'h1F
`define URCP_RST_FREQ_MAIN 8'h50
`define URCP_RST_FREQ_ALT1 8'h00
`define URCP_RST_FREQ_ALT2 8'hAA
`define URCP_RST_SLEEP 8'h7C

// Field positions
`define URCP_CTRL0_BITRATE_HI 2
`define URCP_CTRL0_BITRATE_LO 0
`define URCP_CTRL0_STORED_HI 5
`define URCP_SLEEP_ENTER_BIT 7

// Bitrate codes and rates in bit/s
`define URCP_BR_9600 3'h0
`define URCP_BR_10400 3'h1
`define URCP_BR_19200 3'h2
`define URCP_BR_38400 3'h3
`define URCP_BR_57600 3'h4
`define URCP_BR_115200 3'h5
`define URCP_RATE_9600 9600
`define URCP_RATE_10400 10400
`define URCP_RATE_19200 19200
`define URCP_RATE_38400 38400
`define URCP_RATE_57600 57600
`define URCP_RATE_115200 115200

// Timing in microseconds
`define URCP_T_INIT_US 2000
`define URCP_T_FREQ_CHANGE_US 1000

`endif

// File: logic/urcp_uart_rx.v
// UART byte receiver with programmable divisor and bit-0 entry
module urcp_uart_rx (
   input wire ref_clk,
   input wire rst,
   input wire enable,
   input wire rxd,
   input wire [15:0] div,
   input wire arm_bit0,
   output reg [7:0] data_q,
   output reg valid_q
);
   localparam S_IDLE = 4'b0001;
   localparam S_START = 4'b0010;
   localparam S_DATA = 4'b0100;
   localparam S_STOP = 4'b1000;

   reg [3:0] state_q;
   reg [15:0] cnt_q;
   reg [2:0] bit_q;
   reg [7:0] shift_q;
   reg rxd_prev_q;

   always @(posedge ref_clk) begin
      valid_q <= 1'b0;
      rxd_prev_q <= rxd;
      if (rst || !enable) begin
         state_q <= S_IDLE;
         cnt_q <= 16'h0000;
         bit_q <= 3'h0;
         shift_q <= 8'h00;
         data_q <= 8'h00;
         valid_q <= 1'b0;
         rxd_prev_q <= 1'b1;
      end else begin
         case (state_q)
            S_IDLE: begin
               bit_q <= 3'h0;
               // Start bit already measured: resume at bit 0
               if (arm_bit0) begin
                  state_q <= S_DATA;
                  cnt_q <= {1'b0, div[15:1]};
               end else if (rxd_prev_q && !rxd) begin
                  state_q <= S_START;
                  cnt_q <= {1'b0, div[15:1]};
               end
            end
            S_START: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (rxd) begin
                  state_q <= S_IDLE;
               end else begin
                  state_q <= S_DATA;
                  cnt_q <= div;
               end
            end
            S_DATA: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else begin
                  shift_q <= {rxd, shift_q[7:1]};
                  cnt_q <= div;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     state_q <= S_STOP;
                  end
               end
            end
            S_STOP: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else begin
                  state_q <= S_IDLE;
                  if (rxd) begin
                     data_q <= shift_q;
                     valid_q <= 1'b1;
                  end
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// File: logic/urcp_uart_tx.v
// UART byte transmitter, 8N1, programmable divisor
module urcp_uart_tx (
   input wire ref_clk,
   input wire rst,
   input wire start,
   input wire [7:0] data,
   input wire [15:0] div,
   output reg txd_q,
   output reg busy_q
);
   reg [9:0] shift_q;
   reg [3:0] left_q;
   reg [15:0] cnt_q;

   always @(posedge ref_clk) begin
      if (rst) begin
         txd_q <= 1'b1;
         busy_q <= 1'b0;
         shift_q <= 10'h3FF;
         left_q <= 4'h0;
         cnt_q <= 16'h0000;
      end else if (!busy_q) begin
         txd_q <= 1'b1;
         if (start) begin
            busy_q <= 1'b1;
            shift_q <= {1'b1, data, 1'b0};
            left_q <= 4'hA;
            cnt_q <= 16'h0000;
         end
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end else if (left_q == 4'h0) begin
         busy_q <= 1'b0;
         txd_q <= 1'b1;
      end else begin
         txd_q <= shift_q[0];
         shift_q <= {1'b1, shift_q[9:1]};
         left_q <= left_q - 4'h1;
         cnt_q <= div - 16'h0001;
      end
   end
endmodule

// File: logic/urcp_port.v
// UART register command port: parser, registers, bitrate learning
`include "urcp_defs.vh"

module urcp_port #(
   parameter INIT_CYCLES = `URCP_T_INIT_US * `URCP_CLK_MHZ,
   parameter FREQ_CYCLES = `URCP_T_FREQ_CHANGE_US * `URCP_CLK_MHZ,
   // Identifier value is arbitrary
   parameter [47:0] UNIQUE_IDENTIFIER = 48'h0123456789AB
) (
   input wire ref_clk,
   input wire rst,
   input wire cmd_select_n,
   input wire host_data_in,
   input wire modem_data_out,
   input wire [7:0] active_freq,
   output reg host_data_output_q,
   output reg modem_soft_reset_q,
   output reg powerline_enable_q,
   output reg cmd_mode_q,
   output reg [15:0] link_baud_div_q,
   output reg [7:0] device_control0_q,
   output reg [7:0] device_control1_q,
   output reg [7:0] freq_main_q,
   output reg [7:0] freq_alt1_q,
   output reg [7:0] freq_alt2_q,
   output reg [7:0] sleep_control_q,
   output reg sleep_request_q,
   output reg port_busy_q
);
   localparam P_CMD = 5'b00001;
   localparam P_WADDR = 5'b00010;
   localparam P_WDATA = 5'b00100;
   localparam P_RADDR = 5'b01000;
   localparam P_IDLE = 5'b10000;

   ////////////////////////////////////////////////////////////////////////////
   // Divisor for a bitrate code
   function [15:0] baud_div;
      input [2:0] code;
      reg [31:0] rate;
      reg [31:0] quot;
      begin
         rate = `URCP_RATE_19200;
         case (code)
            `URCP_BR_9600: rate = `URCP_RATE_9600;
            `URCP_BR_10400: rate = `URCP_RATE_10400;
            `URCP_BR_19200: rate = `URCP_RATE_19200;
            `URCP_BR_38400: rate = `URCP_RATE_38400;
            `URCP_BR_57600: rate = `URCP_RATE_57600;
            `URCP_BR_115200: rate = `URCP_RATE_115200;
            default: rate = `URCP_RATE_19200;
         endcase
         quot = (`URCP_CLK_HZ + rate / 2) / rate;
         baud_div = quot[15:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, change accepted when stages two and three agree
   reg sel_s1_q, sel_s2_q, sel_s3_q, sel_q;
   reg rxd_s1_q, rxd_s2_q, rxd_s3_q, rxd_q, rxd_prev_q;

   always @(posedge ref_clk) begin
      if (rst) begin
         sel_s1_q <= 1'b1;
         sel_s2_q <= 1'b1;
         sel_s3_q <= 1'b1;
         sel_q <= 1'b1;
         rxd_s1_q <= 1'b1;
         rxd_s2_q <= 1'b1;
         rxd_s3_q <= 1'b1;
         rxd_q <= 1'b1;
         rxd_prev_q <= 1'b1;
      end else begin
         sel_s1_q <= cmd_select_n;
         sel_s2_q <= sel_s1_q;
         sel_s3_q <= sel_s2_q;
         if (sel_s2_q == sel_s3_q) begin
            sel_q <= sel_s3_q;
         end
         rxd_s1_q <= host_data_in;
         rxd_s2_q <= rxd_s1_q;
         rxd_s3_q <= rxd_s2_q;
         if (rxd_s2_q == rxd_s3_q) begin
            rxd_q <= rxd_s3_q;
         end
         rxd_prev_q <= rxd_q;
      end
   end

   wire cmd_mode = !sel_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bitrate learning from the start bit of the first command byte
   reg learned_q;
   reg measuring_q;
   reg [15:0] meas_cnt_q;
   reg [15:0] host_div_q;
   reg arm_q;

   always @(posedge ref_clk) begin
      arm_q <= 1'b0;
      if (rst || !cmd_mode) begin
         learned_q <= 1'b0;
         measuring_q <= 1'b0;
         meas_cnt_q <= 16'h0000;
         host_div_q <= 16'h0001;
         arm_q <= 1'b0;
      end else if (!learned_q) begin
         if (!measuring_q) begin
            if (rxd_prev_q && !rxd_q) begin
               measuring_q <= 1'b1;
               meas_cnt_q <= 16'h0001;
            end
         end else if (rxd_q) begin
            // First command bit 0 is high, so the low run is one bit time
            learned_q <= 1'b1;
            measuring_q <= 1'b0;
            host_div_q <= meas_cnt_q;
            arm_q <= 1'b1;
         end else if (meas_cnt_q != 16'hFFFF) begin
            meas_cnt_q <= meas_cnt_q + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // UART engines running at the learned host rate
   wire [7:0] rx_data;
   wire rx_valid;
   wire tx_line;
   reg tx_start_q;
   reg [7:0] tx_data_q;

   urcp_uart_rx u_rx (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(cmd_mode && (learned_q || arm_q)),
      .rxd(rxd_q),
      .div(host_div_q),
      .arm_bit0(arm_q),
      .data_q(rx_data),
      .valid_q(rx_valid)
   );

   urcp_uart_tx u_tx (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(tx_start_q),
      .data(tx_data_q),
      .div(host_div_q),
      .txd_q(tx_line),
      .busy_q()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Busy timer for initialisation and carrier change
   localparam [31:0] INIT_CNT = INIT_CYCLES;
   localparam [31:0] FREQ_CNT = FREQ_CYCLES;
   reg [15:0] busy_cnt_q;
   wire busy = busy_cnt_q != 16'h0000;
   reg freq_write_q;

   always @(posedge ref_clk) begin
      if (rst) begin
         busy_cnt_q <= INIT_CNT[15:0];
      end else if (freq_write_q) begin
         busy_cnt_q <= FREQ_CNT[15:0];
      end else if (busy) begin
         busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read-back value for an address
   reg [7:0] rd_value;

   always @* begin
      rd_value = 8'h00;
      case (rx_data)
         `URCP_ADDR_CTRL0: rd_value = device_control0_q;
         `URCP_ADDR_CTRL1: rd_value = device_control1_q;
         `URCP_ADDR_FREQ_MAIN: rd_value = freq_main_q;
         `URCP_ADDR_FREQ_ALT1: rd_value = freq_alt1_q;
         `URCP_ADDR_FREQ_ALT2: rd_value = freq_alt2_q;
         `URCP_ADDR_FREQ_ACTIVE: rd_value = active_freq;
         `URCP_ADDR_SLEEP: rd_value = {1'b0, sleep_control_q[6:0]};
         `URCP_ADDR_UID_4740: rd_value = UNIQUE_IDENTIFIER[47:40];
         `URCP_ADDR_UID_3932: rd_value = UNIQUE_IDENTIFIER[39:32];
         `URCP_ADDR_UID_3124: rd_value = UNIQUE_IDENTIFIER[31:24];
         `URCP_ADDR_UID_2316: rd_value = UNIQUE_IDENTIFIER[23:16];
         `URCP_ADDR_UID_1508: rd_value = UNIQUE_IDENTIFIER[15:8];
         `URCP_ADDR_UID_0700: rd_value = UNIQUE_IDENTIFIER[7:0];
         default: rd_value = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command parser and register file
   reg [4:0] pstate_q;
   reg [7:0] waddr_q;

   always @(posedge ref_clk) begin
      tx_start_q <= 1'b0;
      freq_write_q <= 1'b0;
      sleep_request_q <= 1'b0;
      if (rst) begin
         pstate_q <= P_CMD;
         waddr_q <= 8'h00;
         tx_data_q <= 8'h00;
         tx_start_q <= 1'b0;
         freq_write_q <= 1'b0;
         sleep_request_q <= 1'b0;
         device_control0_q <= `URCP_RST_CTRL0;
         device_control1_q <= `URCP_RST_CTRL1;
         freq_main_q <= `URCP_RST_FREQ_MAIN;
         freq_alt1_q <= `URCP_RST_FREQ_ALT1;
         freq_alt2_q <= `URCP_RST_FREQ_ALT2;
         sleep_control_q <= `URCP_RST_SLEEP;
      end else if (!cmd_mode) begin
         pstate_q <= P_CMD;
      end else if (rx_valid && !busy) begin
         case (pstate_q)
            P_CMD: begin
               if (rx_data == `URCP_CMD_WRITE) begin
                  pstate_q <= P_WADDR;
               end else if (rx_data == `URCP_CMD_READ) begin
                  pstate_q <= P_RADDR;
               end
            end
            P_WADDR: begin
               waddr_q <= rx_data;
               pstate_q <= P_WDATA;
            end
            P_WDATA: begin
               pstate_q <= P_CMD;
               // Stored values survive mode exits, only rst restores them
               case (waddr_q)
                  `URCP_ADDR_CTRL0: device_control0_q <= {2'b00, rx_data[`URCP_CTRL0_STORED_HI:0]};
                  `URCP_ADDR_CTRL1: device_control1_q <= rx_data;
                  `URCP_ADDR_FREQ_MAIN: begin
                     freq_main_q <= rx_data;
                     freq_write_q <= 1'b1;
                  end
                  `URCP_ADDR_FREQ_ALT1: freq_alt1_q <= rx_data;
                  `URCP_ADDR_FREQ_ALT2: freq_alt2_q <= rx_data;
                  `URCP_ADDR_SLEEP: begin
                     sleep_control_q <= {1'b0, rx_data[6:0]};
                     sleep_request_q <= rx_data[`URCP_SLEEP_ENTER_BIT];
                  end
                  default: begin
                  end
               endcase
            end
            P_RADDR: begin
               tx_data_q <= rd_value;
               tx_start_q <= 1'b1;
               pstate_q <= P_CMD;
            end
            default: begin
               pstate_q <= P_CMD;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode outputs and serial routing
   always @(posedge ref_clk) begin
      if (rst) begin
         cmd_mode_q <= 1'b0;
         modem_soft_reset_q <= 1'b1;
         powerline_enable_q <= 1'b0;
         host_data_output_q <= 1'b1;
         link_baud_div_q <= baud_div(`URCP_BR_19200);
         port_busy_q <= 1'b1;
      end else begin
         cmd_mode_q <= cmd_mode;
         modem_soft_reset_q <= cmd_mode || busy;
         powerline_enable_q <= !cmd_mode && !busy;
         port_busy_q <= busy;
         if (cmd_mode) begin
            host_data_output_q <= tx_line;
            link_baud_div_q <= host_div_q;
         end else begin
            host_data_output_q <= modem_data_out;
            link_baud_div_q <= baud_div(device_control0_q[`URCP_CTRL0_BITRATE_HI:`URCP_CTRL0_BITRATE_LO]);
         end
      end
   end
endmodule

// File: tb/urcp_port_monitor.sv
// Port checker for the register command port
module urcp_port_monitor #(
   parameter INIT_CYCLES = 40000,
   parameter FREQ_CYCLES = 20000
) (
   input logic ref_clk,
   input logic rst,
   input logic cmd_select_n,
   input logic modem_data_out,
   input logic host_data_output_q,
   input logic modem_soft_reset_q,
   input logic powerline_enable_q,
   input logic cmd_mode_q,
   input logic [15:0] link_baud_div_q,
   input logic [7:0] device_control0_q,
   input logic [7:0] freq_main_q,
   input logic sleep_request_q,
   input logic port_busy_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   int busy_run_q;
   always @(posedge ref_clk) begin
      if (rst || !port_busy_q) begin
         busy_run_q <= 0;
      end else begin
         busy_run_q <= busy_run_q + 1;
      end
   end
   function automatic logic [15:0] exp_div(input logic [2:0] c);
      case (c)
         3'h0: return 16'h0823;
         3'h1: return 16'h0783;
         3'h3: return 16'h0209;
         3'h4: return 16'h015B;
         3'h5: return 16'h00AE;
         default: return 16'h0412;
      endcase
   endfunction
   AST_SELECT_ENTER: assert property ($fell(cmd_select_n) |-> ##[1:8] cmd_mode_q)
      else $error("command mode not entered");
   AST_SELECT_EXIT: assert property ($rose(cmd_select_n) |-> ##[1:8] !cmd_mode_q)
      else $error("command mode not left");
   AST_MODE_QUIET: assert property (cmd_mode_q && $past(cmd_mode_q) |-> modem_soft_reset_q && !powerline_enable_q)
      else $error("powerline active in command mode");
   AST_ENABLE_EXCL: assert property (powerline_enable_q == !modem_soft_reset_q)
      else $error("enable and soft reset disagree");
   AST_BAUD_RESTORE: assert property (!cmd_mode_q [*3] |-> link_baud_div_q == exp_div(device_control0_q[2:0]))
      else $error("divisor does not follow control bits");
   AST_RESERVED_ZERO: assert property (device_control0_q[7:6] == 2'h0)
      else $error("control bits 7:6 not zero");
   AST_PASS_THROUGH: assert property ((!cmd_mode_q && !$past(rst)) [*3] |-> host_data_output_q == $past(modem_data_out))
      else $error("modem line not passed to host");
   AST_INIT_BUSY: assert property ($fell(rst) |-> port_busy_q [*8])
      else $error("not busy after reset");
   AST_CARRIER_BUSY: assert property (!$stable(freq_main_q) && !$past(rst) |-> ##[0:2] port_busy_q)
      else $error("carrier write did not start busy");
   AST_BUSY_BOUND: assert property (busy_run_q <= INIT_CYCLES + FREQ_CYCLES)
      else $error("busy too long");
   COV_ENTER: cover property ($rose(cmd_mode_q));
   COV_SLEEP: cover property (sleep_request_q);
   COV_IDLE: cover property ($fell(port_busy_q));
endmodule
bind urcp_port urcp_port_monitor #(.INIT_CYCLES(INIT_CYCLES), .FREQ_CYCLES(FREQ_CYCLES)) mon_u (
   .ref_clk(ref_clk), .rst(rst), .cmd_select_n(cmd_select_n), .modem_data_out(modem_data_out),
   .host_data_output_q(host_data_output_q), .modem_soft_reset_q(modem_soft_reset_q),
   .powerline_enable_q(powerline_enable_q), .cmd_mode_q(cmd_mode_q), .link_baud_div_q(link_baud_div_q),
   .device_control0_q(device_control0_q), .freq_main_q(freq_main_q), .sleep_request_q(sleep_request_q),
   .port_busy_q(port_busy_q));

// File: tb/urcp_host_model.sv
// Host controller model: select pin and UART byte line
module urcp_host_model #(
   parameter int BIT_CYC = 174
) (
   input logic ref_clk,
   input logic host_data_output_q,
   output logic cmd_select_n,
   output logic host_data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   int to_err = 0;
   initial begin
      cmd_select_n = 1'b1;
      host_data_in = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic enter();
      cyc(1);
      cmd_select_n = 1'b0;
      cyc(10);
   endtask
   task automatic leave();
      cyc(4);
      cmd_select_n = 1'b1;
      cyc(10);
   endtask
   // Short stop lets the caller catch an early answer
   task automatic send_byte(input logic [7:0] b, input int stop_cyc);
      logic [8:0] fr;
      fr = {b, 1'b0};
      for (int i = 0; i < 9; i++) begin
         host_data_in = fr[i];
         cyc(BIT_CYC);
      end
      host_data_in = 1'b1;
      cyc(stop_cyc);
   endtask
   task automatic recv_byte(output logic [7:0] b);
      int n;
      n = 0;
      b = 8'h00;
      while (host_data_output_q !== 1'b0 && n < 4000) begin
         cyc(1);
         n++;
      end
      if (n >= 4000) begin
         to_err++;
      end
      cyc(BIT_CYC + BIT_CYC / 2);
      for (int i = 0; i < 8; i++) begin
         b[i] = host_data_output_q;
         cyc(BIT_CYC);
      end
      cyc(BIT_CYC / 2);
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      enter();
      send_byte(8'hF5, BIT_CYC);
      send_byte(a, BIT_CYC);
      send_byte(d, BIT_CYC);
      leave();
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      enter();
      send_byte(8'hFD, BIT_CYC);
      send_byte(a, BIT_CYC / 4);
      recv_byte(d);
      leave();
   endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the register command port
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic modem_data_out = 1'b1;
   logic [7:0] active_freq = 8'h5A;
   wire cmd_select_n, host_data_in, host_data_output_q, modem_soft_reset_q, powerline_enable_q, cmd_mode_q;
   wire sleep_request_q, port_busy_q;
   wire [15:0] link_baud_div_q;
   wire [7:0] ctrl0, ctrl1, fmain, falt1, falt2, sleepc;
   int bad_count = 0;
   int n_tests = 0;
   int sleep_seen = 0;
   logic [7:0] rd;
   logic [7:0] ra [5] = '{8'h03, 8'h9B, 8'h05, 8'h40, 8'h00};
   logic [7:0] re [5] = '{8'h34, 8'hAB, 8'h5A, 8'h00, 8'h2A};
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (sleep_request_q === 1'b1) begin
         sleep_seen++;
      end
   end
   urcp_port #(.INIT_CYCLES(50), .FREQ_CYCLES(400)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .cmd_select_n(cmd_select_n), .host_data_in(host_data_in),
      .modem_data_out(modem_data_out), .active_freq(active_freq), .host_data_output_q(host_data_output_q),
      .modem_soft_reset_q(modem_soft_reset_q), .powerline_enable_q(powerline_enable_q),
      .cmd_mode_q(cmd_mode_q), .link_baud_div_q(link_baud_div_q), .device_control0_q(ctrl0),
      .device_control1_q(ctrl1), .freq_main_q(fmain), .freq_alt1_q(falt1), .freq_alt2_q(falt2),
      .sleep_control_q(sleepc), .sleep_request_q(sleep_request_q), .port_busy_q(port_busy_q));
   urcp_host_model #(.BIT_CYC(174)) host_u (
      .ref_clk(ref_clk), .host_data_output_q(host_data_output_q), .cmd_select_n(cmd_select_n),
      .host_data_in(host_data_in));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (port_busy_q !== 1'b0 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         complete_run();
      end
   endtask
   task automatic chk_defaults();
      chk("ctrl0", 8'h2A, ctrl0);
      chk("ctrl1", 8'h1F, ctrl1);
      chk("fmain", 8'h50, fmain);
      chk("falt1", 8'h00, falt1);
      chk("falt2", 8'hAA, falt2);
      chk("sleepc", 8'h7C, sleepc);
      chk("div", 16'h0412, link_baud_div_q);
      chk("busy", 1'b1, port_busy_q);
      chk("pl_en", 1'b0, powerline_enable_q);
   endtask
   initial begin
      #5000000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      chk_defaults();
      rst = 1'b0;
      wait_idle();
      chk("pl_en", 1'b1, powerline_enable_q);
      modem_data_out = 1'b0;
      host_u.cyc(2);
      chk("hdo", 1'b0, host_data_output_q);
      modem_data_out = 1'b1;
      host_u.enter();
      host_u.send_byte(8'hF5, 174);
      chk("mode", 1'b1, cmd_mode_q);
      chk("soft_rst", 1'b1, modem_soft_reset_q);
      chk("pl_en", 1'b0, powerline_enable_q);
      chk("learn", 1'b1, link_baud_div_q >= 16'h00AB && link_baud_div_q <= 16'h00B1);
      host_u.send_byte(8'h03, 174);
      host_u.send_byte(8'h34, 174);
      host_u.leave();
      chk("falt1", 8'h34, falt1);
      chk("div", 16'h0412, link_baud_div_q);
      chk("pl_en", 1'b1, powerline_enable_q);
      host_u.write_reg(8'h9B, 8'h55);
      for (int i = 0; i < 5; i++) begin
         host_u.read_reg(ra[i], rd);
         chk("read", re[i], rd);
      end
      host_u.write_reg(8'h00, 8'hC5);
      chk("ctrl0", 8'h05, ctrl0);
      chk("div", 16'h00AE, link_baud_div_q);
      host_u.enter();
      host_u.send_byte(8'h13, 174);
      host_u.send_byte(8'hF5, 174);
      host_u.send_byte(8'h01, 174);
      host_u.send_byte(8'h0E, 174);
      host_u.leave();
      chk("ctrl1", 8'h0E, ctrl1);
      host_u.enter();
      host_u.send_byte(8'hF5, 174);
      host_u.leave();
      host_u.write_reg(8'h04, 8'h11);
      chk("falt2", 8'h11, falt2);
      host_u.write_reg(8'h06, 8'h83);
      chk("sleepc", 8'h03, sleepc);
      chk("sleep_req", 16'h0001, 16'(sleep_seen));
      host_u.write_reg(8'h02, 8'h64);
      chk("busy", 1'b1, port_busy_q);
      chk("fmain", 8'h64, fmain);
      wait_idle();
      chk("falt1", 8'h34, falt1);
      chk("to_err", 0, host_u.to_err);
      rst = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk_defaults();
      rst = 1'b0;
      host_u.cyc(10);
      chk("busy", 1'b1, port_busy_q);
      complete_run();
   end
endmodule
